// ---- bench/sac_adc_ctrl_sva.sv ----
// Purpose: Port checker of the conversion control
// Assumes: Pins reach the core two clocks late
// Notes:   Bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module sac_adc_ctrl_sva #(
    parameter int DIV_RATIO = 8  // Divider ratio
) (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       cs_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic       cmp_hi,
    input wire logic [7:0] dac_code,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       conversion_done_n
);
    logic [7:0] cnt_q;  // Clocks since first trial code
    // Restart the count when the first trial code loads
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 8'hff;
        end else if (dac_code == 8'h80 && $past(dac_code) == 8'h00) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_req; !$past(cs_n, 2) && !$past(wr_n, 2); endsequence
    sequence s_rel; !$past(cs_n, 3) && !$past(wr_n, 3) && ($past(cs_n, 2) || $past(wr_n, 2));
    endsequence
    sequence s_done_low; (!conversion_done_n)[*8] ##1 conversion_done_n; endsequence
    property p_oe; data_oe == (!$past(cs_n, 2) && !$past(rd_n, 2)); endproperty
    property p_hold; s_req |=> dac_code == 8'h00 && conversion_done_n; endproperty
    property p_rel; s_rel |-> ##[1:9] dac_code == 8'h80; endproperty
    property p_msb;
        $changed(dac_code) && $past(dac_code) == 8'h80 && dac_code != 8'h00
            |-> dac_code[6] && dac_code[5:0] == 6'h00;
    endproperty
    property p_time; $fell(conversion_done_n) |-> cnt_q >= 8 * DIV_RATIO && cnt_q <= 8 * DIV_RATIO + 4;
    endproperty
    property p_latch; $changed(data_out) |=> $fell(conversion_done_n); endproperty
    property p_cont; $fell(conversion_done_n) && data_oe |-> s_done_low; endproperty
    property p_clear;
        $rose(conversion_done_n) |-> $past(data_oe) || (!$past(cs_n, 3) && !$past(wr_n, 3));
    endproperty
    a_oe: assert property (p_oe) else $error("bus enable wrong");
    a_hold: assert property (p_hold) else $error("not held in reset");
    a_rel: assert property (p_rel) else $error("late start");
    a_msb: assert property (p_msb) else $error("bit order wrong");
    a_time: assert property (p_time) else $error("conversion length wrong");
    a_latch: assert property (p_latch) else $error("latch not before done");
    a_cont: assert property (p_cont) else $error("done pulse length wrong");
    a_clear: assert property (p_clear) else $error("done cleared without cause");
endmodule : sac_adc_ctrl_sva
bind sac_adc_ctrl sac_adc_ctrl_sva #(.DIV_RATIO(DIV_RATIO)) u_sva (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .cmp_hi(cmp_hi),
    .dac_code(dac_code), .data_out(data_out), .data_oe(data_oe),
    .conversion_done_n(conversion_done_n));
`default_nettype wire

// ---- bench/sac_cmp_model.sv ----
// Purpose: Comparator in front of the ladder
// Assumes: Input is an unsigned code against the trial code
// Notes:   Answers at once
`timescale 1ns/100ps
`default_nettype none
module sac_cmp_model (
    input  wire logic [7:0] vin,       // Input level as a code
    input  wire logic [7:0] dac_code,  // Trial code
    output logic            cmp_hi     // Input not below trial
);
    assign cmp_hi = (vin >= dac_code);
endmodule : sac_cmp_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench of the conversion control
// Assumes: Comparator model stands in for the analog side
// Notes:   Expected codes queued by the driver, checked at done
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       ref_clk = 1'b0, sys_rst = 1'b1, cs_n = 1'b1, wr_q = 1'b1, rd_n = 1'b1;
    logic       free_run = 1'b0, done_d = 1'b1;  // Feedback mode, done history
    logic [7:0] vin = 8'h00;                      // Input level
    logic [7:0] exp_q[$];                         // Expected results
    int         n_errors = 0, comparisons = 0, seed = 32'h55ebc4be, i;
    wire logic  wr_n, cmp_hi, data_oe, conversion_done_n;
    wire logic [7:0] dac_code, data_out;
    assign wr_n = free_run ? conversion_done_n : wr_q;
    always #2.5 ref_clk = ~ref_clk;
    sac_adc_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .cmp_hi(cmp_hi), .dac_code(dac_code), .data_out(data_out),
        .data_oe(data_oe), .conversion_done_n(conversion_done_n));
    sac_cmp_model u_cmp (.vin(vin), .dac_code(dac_code), .cmp_hi(cmp_hi));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    // Start pulse; select stays low while a read is held
    task automatic start(input int w);
        cs_n = 1'b0;
        wr_q = 1'b0;
        cyc(w);
        wr_q = 1'b1;
        cyc(1);
        cs_n = rd_n;
    endtask : start
    // Bounded wait for done low
    task automatic wait_done;
        for (i = 0; i < 200 && conversion_done_n !== 1'b0; i++) cyc(1);
        if (i == 200) begin
            check({7'h00, conversion_done_n}, 8'h00);
            end_sim();
        end
    endtask : wait_done
    // Read after the done set time, then release the bus
    task automatic rd_cycle;
        cyc(8);
        cs_n = 1'b0;
        rd_n = 1'b0;
        cyc(3);
        check({7'h00, data_oe}, 8'h01);
        cs_n = 1'b1;
        rd_n = 1'b1;
        cyc(3);
        check({7'h00, conversion_done_n}, 8'h01);
        check({7'h00, data_oe}, 8'h00);
    endtask : rd_cycle
    // Result compared at each fall of done
    always @(negedge ref_clk) begin
        if (done_d === 1'b1 && conversion_done_n === 1'b0) begin
            if (exp_q.size() == 0) check(data_out, 8'hxx);
            else check(data_out, exp_q.pop_front());
        end
        done_d = conversion_done_n;
    end
    initial begin
        cyc(12);
        sys_rst = 1'b0;
        cyc(2);
        // Boundary and random codes, hold lengths growing
        for (int k = 0; k < 6; k++) begin
            vin = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
            exp_q.push_back(vin);
            start(1 + k * 7);
            wait_done();
            rd_cycle();
        end
        // Abort in mid-search with a new level
        vin = 8'h3c;
        start(2);
        cyc(30);
        vin = 8'hc5;
        exp_q.push_back(vin);
        start(2);
        wait_done();
        rd_cycle();
        // Output held enabled throughout
        rd_n = 1'b0;
        vin = 8'h5a;
        exp_q.push_back(vin);
        start(3);
        wait_done();
        cyc(12);
        check({7'h00, conversion_done_n}, 8'h01);
        rd_n = 1'b1;
        cs_n = 1'b1;
        cyc(4);
        // Free running after one start pulse
        vin = 8'h96;
        repeat (3) exp_q.push_back(vin);
        cs_n = 1'b0;
        wr_q = 1'b0;
        cyc(2);
        free_run = 1'b1;
        for (i = 0; i < 400 && exp_q.size() != 0; i++) cyc(1);
        check({7'h00, exp_q.size() == 0}, 8'h01);
        end_sim();
    end
endmodule : testbench
`default_nettype wire

// ---- rtl/sac_adc_ctrl.sv ----
// Purpose: Start, reset and completion control of an 8-bit SAR converter
// Assumes: Pins are asynchronous to ref_clk and are synchronised here
// Notes:   Analog ladder and comparator sit outside; cmp_hi is its answer
`timescale 1ns/100ps
`default_nettype none
`include "sac_regs.svh"

module sac_adc_ctrl #(
    parameter int DIV_RATIO = `SAC_DIV_RATIO,  // Divider ratio
    parameter int PHASE_W   = `SAC_PHASE_W,    // Divider counter width
    parameter int RES_BITS  = `SAC_RES_BITS,   // Result width
    parameter int SET_CLKS  = `SAC_SET_CLKS    // Done set length
) (
    input  wire logic                ref_clk,            // Reference clock
    input  wire logic                sys_rst,            // Async reset, high
    input  wire logic                cs_n,               // Chip select, low
    input  wire logic                wr_n,               // Start strobe, low
    input  wire logic                rd_n,               // Read strobe, low
    input  wire logic                cmp_hi,             // Input not below trial
    output logic      [RES_BITS-1:0] dac_code,           // Trial code to ladder
    output logic      [RES_BITS-1:0] data_out,           // Latched result
    output logic                     data_oe,            // Bus drive enable
    output logic                     conversion_done_n   // Done flag, low
);

    // Sequence in reference clocks, counted from the edge that loads the MSB
    //   Edge 0:  trial code with only the MSB set on the ladder
    //   Edge 8:  MSB decided, next lower bit set as trial
    //   Edge 64: last bit decided, search over
    //   Edge 65: result moved into the output latch
    //   Edge 66: done flip-flop set, pin goes low
    //   Edge 73: last edge of the set window
    // Pin latency
    //   Every pin is seen two edges after it settles
    //   Edge detection adds one more flip-flop on the start strobe
    // Start handling
    //   Select and start strobe low together act as a level, not an edge
    //   The request wins over every state, so a long strobe holds reset
    //   Release is taken at the first divider pulse that finds it gone
    //   Hence the one to eight clock spread on the start latency
    // Done handling
    //   Set window beats a read, so an early read cannot clear done
    //   A start request clears done and suppresses the set window
    //   Feedback of done to the start strobe therefore gives a short pulse
    // Hazards
    //   The comparator answer is sampled through the synchroniser
    //   It must settle within six clocks of a trial code change
    //   A start strobe edge with select high clears the search only
    //   Data bus drive is only the enable; the pad holds the three-state

    // Pin vector order inside the synchroniser
    localparam int PIN_CS  = 0;
    localparam int PIN_WR  = 1;
    localparam int PIN_RD  = 2;
    localparam int PIN_CMP = 3;

    // Idle level of every pin, one bit per synchroniser
    localparam logic [`SAC_PIN_COUNT-1:0] PIN_RST = `SAC_PIN_RST;

    // Synchroniser stages and the delayed strobe for edge detection
    logic [`SAC_PIN_COUNT-1:0] pin_raw;     // Raw pins
    logic [`SAC_PIN_COUNT-1:0] meta_q;      // First stage only
    logic [`SAC_PIN_COUNT-1:0] sync_q;      // Second stage, safe to use
    logic                      wr_dly_q;    // Start strobe one clock later

    // Synchronised pin levels
    logic cs_s;
    logic wr_s;
    logic rd_s;
    logic cmp_s;

    // Decoded events
    logic start_req;   // Select and start strobe both low
    logic wr_fall;     // Start strobe falling edge
    logic read_en;     // Select and read strobe both low
    logic tick;        // Internal sequencing clock pulse

    // Sequencer state
    sac_pkg::sac_state_t                      state_q;   // Current state
    logic [PHASE_W-1:0]                       phase_q;   // Divider phase
    logic [`SAC_BIT_IDX_W-1:0]                bit_q;     // Bit under test
    logic [`SAC_BIT_IDX_W-1:0]                bit_m1;    // Next lower bit
    logic [`SAC_SET_CNT_W-1:0]                set_cnt_q; // Done set length
    logic [RES_BITS-1:0]                      sar_q;     // Approximation
    logic [RES_BITS-1:0]                      data_q;    // Output latch
    logic                                     done_q;    // Done flip-flop

    // Pins gathered for the synchroniser loop
    assign pin_raw = {
        cmp_hi,   // Comparator answer
        rd_n,     // Read strobe
        wr_n,     // Start strobe
        cs_n      // Chip select
    };

    // Two flip-flops per pin before any logic looks at it
    genvar gi;
    generate
        for (gi = 0; gi < `SAC_PIN_COUNT; gi++) begin : g_sync
            // One synchroniser per pin
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    // Idle level, so no false edge follows reset
                    meta_q[gi] <= PIN_RST[gi];
                    sync_q[gi] <= PIN_RST[gi];
                end else begin
                    // Pin shifts through both stages
                    meta_q[gi] <= pin_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    // Named views of the synchronised pins
    assign cs_s  = sync_q[PIN_CS];
    assign wr_s  = sync_q[PIN_WR];
    assign rd_s  = sync_q[PIN_RD];
    assign cmp_s = sync_q[PIN_CMP];

    // Delayed start strobe, reads only the second stage
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Strobe idles high
            wr_dly_q <= 1'b1;
        end else begin
            // Last synchronised level
            wr_dly_q <= wr_s;
        end
    end

    // Event decode
    // Level request: held as long as both stay low
    assign start_req = ~cs_s & ~wr_s;
    // Falling edge of the strobe, with or without select
    assign wr_fall   = wr_dly_q & ~wr_s;
    // Read access: both low
    assign read_en   = ~cs_s & ~rd_s;
    // Index of the next trial bit
    assign bit_m1    = bit_q - `SAC_BIT_IDX_W'(1);

    // Free-running divider; one pulse every DIV_RATIO clocks
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Phase zero after reset
            phase_q <= '0;
        end else if (phase_q == PHASE_W'(DIV_RATIO - 1)) begin
            // Wrap at the end of a sequencing period
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + PHASE_W'(1);
        end
    end

    // Sequencing pulse at one eighth of the reference rate
    assign tick = (phase_q == PHASE_W'(DIV_RATIO - 1));

    // Sequencer: hold, search, transfer and signal
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= sac_pkg::SAC_ST_IDLE;
        end else if (start_req) begin
            // Request wins in any state, even mid-search
            state_q <= sac_pkg::SAC_ST_HOLD;
        end else begin
            case (state_q)
                sac_pkg::SAC_ST_IDLE: begin
                    // Waiting for a start request
                    state_q <= sac_pkg::SAC_ST_IDLE;
                end
                sac_pkg::SAC_ST_HOLD: begin
                    // Leave reset only on a pulse after release
                    if (tick) begin
                        state_q <= sac_pkg::SAC_ST_CONV;
                    end
                end
                sac_pkg::SAC_ST_CONV: begin
                    // Last bit decided ends the search
                    if (tick && bit_q == '0) begin
                        state_q <= sac_pkg::SAC_ST_XFER;
                    end
                end
                sac_pkg::SAC_ST_XFER: begin
                    // Result moves to the latch this edge
                    state_q <= sac_pkg::SAC_ST_SIG;
                end
                sac_pkg::SAC_ST_SIG: begin
                    // Set signal held for SET_CLKS clocks
                    if (set_cnt_q == `SAC_SET_CNT_W'(SET_CLKS - 1)) begin
                        state_q <= sac_pkg::SAC_ST_IDLE;
                    end
                end
                default: begin
                    // Unused code returns to idle
                    state_q <= sac_pkg::SAC_ST_IDLE;
                end
            endcase
        end
    end

    // Length of the done set signal
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            set_cnt_q <= '0;
        end else if (state_q == sac_pkg::SAC_ST_SIG && !start_req) begin
            // Count the clocks of the set window
            set_cnt_q <= set_cnt_q + `SAC_SET_CNT_W'(1);
        end else begin
            // Ready for the next window
            set_cnt_q <= '0;
        end
    end

    // Approximation register and the bit under test
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sar_q <= '0;
            bit_q <= '0;
        end else if (start_req || wr_fall) begin
            // Approximation register cleared, no trial bit yet
            sar_q <= '0;
            bit_q <= `SAC_BIT_IDX_W'(RES_BITS - 1);
        end else if (state_q == sac_pkg::SAC_ST_HOLD && tick) begin
            // First stage loaded: MSB is tried first
            sar_q                 <= '0;
            sar_q[RES_BITS-1]     <= 1'b1;
            bit_q                 <= `SAC_BIT_IDX_W'(RES_BITS - 1);
        end else if (state_q == sac_pkg::SAC_ST_CONV && tick) begin
            // Keep the trial bit only if input is not below it
            sar_q[bit_q] <= cmp_s;
            if (bit_q != '0) begin
                // Next lower bit becomes the trial
                sar_q[bit_m1] <= 1'b1;
                bit_q         <= bit_m1;
            end
        end
    end

    // Trial code to the ladder follows the register
    assign dac_code = sar_q;

    // Output latch, loaded only when a search completes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // No result yet
            data_q <= '0;
        end else if (state_q == sac_pkg::SAC_ST_XFER && !start_req) begin
            // Search finished; an abort leaves the old result
            data_q <= sar_q;
        end
    end

    // Done flip-flop; a start request beats the set signal, which beats the read clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Nothing finished yet
            done_q <= 1'b0;
        end else if (state_q == sac_pkg::SAC_ST_SIG && !start_req) begin
            // Set window drives the flag every clock
            done_q <= 1'b1;
        end else if (start_req) begin
            // New start cancels an unread result flag
            done_q <= 1'b0;
        end else if (read_en) begin
            // Read access acknowledges the result
            done_q <= 1'b0;
        end
    end

    // Done pin low while the flip-flop is set
    assign conversion_done_n = ~done_q;

    // Bus drive only while selected and read
    assign data_oe  = read_en;
    assign data_out = data_q;

endmodule : sac_adc_ctrl

`default_nettype wire

// ---- rtl/sac_pkg.sv ----
// Purpose: Types of the conversion control
// Assumes: Constants come from sac_regs.svh
// Notes:   Nothing is imported; use sac_pkg::name
package sac_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        SAC_ST_IDLE,
        SAC_ST_HOLD,
        SAC_ST_CONV,
        SAC_ST_XFER,
        SAC_ST_SIG
    } sac_state_t;

endpackage : sac_pkg

// ---- rtl/sac_regs.svh ----
// Purpose: Timing counts and code constants of the conversion control
// Assumes: One 200 MHz reference clock drives the whole block
// Notes:   Definitions only
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// Reference clock period in ns
`define SAC_CLK_PERIOD_NS 5
// Internal sequencing clock is the reference divided by this
`define SAC_DIV_RATIO     8
// Width of the divider phase counter
`define SAC_PHASE_W       3
// Result width in bits
`define SAC_RES_BITS      8
// Width of the bit index counter
`define SAC_BIT_IDX_W     3
// Reference clocks the done set signal is held
`define SAC_SET_CLKS      8
// Width of the done set counter
`define SAC_SET_CNT_W     3
// Least gap from done to read strobe, in reference clocks
`define SAC_READ_GAP_CLKS 8
// Number of synchronised pin inputs
`define SAC_PIN_COUNT     4
// Reset level of the pin synchronisers
`define SAC_PIN_RST       4'hf

`endif
